/* File: init_pkg.sv */
// Package holding register offsets, field layouts, reset values and timing for the init block.
package init_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_MODE   = 4'h0;
  localparam logic [3:0] OFS_POWER  = 4'h1;
  localparam logic [3:0] OFS_PINS   = 4'h2;
  localparam logic [3:0] OFS_FRAME  = 4'h3;
  localparam logic [3:0] OFS_CTRL   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int POW_OSC  = 0;
  localparam int POW_DISP = 1;
  localparam int POW_REG  = 2;
  localparam int POW_PUMP = 3;
  localparam int POW_BIAS = 4;
  localparam int CTRL_SWRST = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0] DUTY_RST  = 4'hF;
  localparam logic [2:0] BIAS_RST  = 3'h5;
  localparam logic [4:0] POWER_RST = 5'h00;
  localparam logic [3:0] PIN_MODE_RST = 4'h0;
  localparam logic [3:0] PIN_LVL_RST  = 4'h0;
  localparam logic [3:0] FRAME_RST = 4'hA;
  localparam logic [1:0] BLINK_RST = 2'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ      = 25000000;
  localparam int INIT_TIME_US = 1000;
  localparam int INIT_CYCLES = CLK_HZ / 1000000 * INIT_TIME_US;
  localparam int CNT_W       = 16;

endpackage

/* File: cfg_if.sv */
// Interface carrying the configuration state from the register file to the output stage.
interface cfg_if;
  logic [3:0] duty;
  logic [2:0] bias;
  logic [4:0] power;
  logic [3:0] pin_pwm;
  logic [3:0] pin_level;
  logic [3:0] frame;
  logic [1:0] blink;
  logic       busy;
  modport src (output duty, bias, power, pin_pwm, pin_level, frame, blink, busy);
  modport dst (input duty, bias, power, pin_pwm, pin_level, frame, blink, busy);
endinterface

/* File: out_stage.sv */
// Output stage that forces driver pins to ground while the display or init holds them.
module out_stage #(
  parameter int NGPO = 4
) (
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // Configuration.
  cfg_if.dst                   cfg,
  // Pin levels.
  output logic                 drive_on,
  output logic [NGPO-1:0]      general_output_pin
);

  typedef struct packed {
    logic            drive_on;
    logic [NGPO-1:0] pins;
  } out_s;

  out_s st;
  out_s next_st;

  // Commons and segments drive only with display and oscillator both on.
  always_comb begin
    next_st = st;
    next_st.drive_on = cfg.power[init_pkg::POW_OSC] & cfg.power[init_pkg::POW_DISP] & ~cfg.busy;
    for (int i = 0; i < NGPO; i++) begin
      next_st.pins[i] = cfg.busy ? 1'b0 : cfg.pin_level[i];
    end
  end

  // Register the outputs; reset lands them at ground.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign drive_on = st.drive_on;
  assign general_output_pin = st.pins;

  pins_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.busy |=> (general_output_pin == '0) && !drive_on)
    else $error("pins not low during init");

endmodule

/* File: lcd_init.sv */
// Power-on initialisation and configuration registers of the LCD controller.
//
// Notes on behaviour
// - Reset loads every configuration register with defaults; display memory is untouched.
// - Default drive mode is one-sixteenth duty, one-fifth bias.
// - Oscillator stopped and display off until software enables them.
// - Commons, segments and general outputs sit at ground after reset.
// - Regulator, charge pump and bias circuit are off after reset.
// - General outputs default to binary mode, pulse-width mode off.
// - Frame rate field defaults to code 1010, nominal 200 Hz.
// - Blinking defaults to off.
module lcd_init #(
  parameter int INIT_CYCLES = init_pkg::INIT_CYCLES,
  parameter int NGPO        = 4
) (
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // Register port.
  input  wire logic [3:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic [7:0]           rdata,
  // Configuration outputs.
  output logic [3:0]           duty,
  output logic [2:0]           bias,
  output logic [4:0]           power,
  output logic [3:0]           pin_pwm,
  output logic [3:0]           frame,
  output logic [1:0]           blink,
  output logic                 busy,
  // Pins.
  output logic                 drive_on,
  output logic [NGPO-1:0]      general_output_pin
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0]               duty;
    logic [2:0]               bias;
    logic [4:0]               power;
    logic [3:0]               pin_pwm;
    logic [3:0]               pin_level;
    logic [3:0]               frame;
    logic [1:0]               blink;
    logic                     busy;
    logic [init_pkg::CNT_W-1:0] cnt;
    logic [7:0]               rdata;
  } regs_s;

  // Display memory is kept outside this block, so neither reset can disturb it.
  regs_s st;
  regs_s next_st;
  cfg_if cfg ();

  // Load the documented defaults and restart the settle counter.
  function automatic regs_s defaults(input regs_s cur);
    regs_s d;
    d = cur;
    d.duty      = init_pkg::DUTY_RST;
    d.bias      = init_pkg::BIAS_RST;
    d.power     = init_pkg::POWER_RST;
    d.pin_pwm   = init_pkg::PIN_MODE_RST;
    d.pin_level = init_pkg::PIN_LVL_RST;
    d.frame     = init_pkg::FRAME_RST;
    d.blink     = init_pkg::BLINK_RST;
    d.busy      = 1'b1;
    d.cnt       = '0;
    return d;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // Settle counter ends the init window; writes are ignored meanwhile.
    if (st.busy) begin
      if (st.cnt == init_pkg::CNT_W'(INIT_CYCLES - 1)) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
    if (wr && !st.busy) begin
      unique case (addr)
        init_pkg::OFS_MODE: begin
          next_st.duty = wdata[3:0];
          next_st.bias = wdata[6:4];
        end
        init_pkg::OFS_POWER: next_st.power = wdata[4:0];
        init_pkg::OFS_PINS: begin
          next_st.pin_pwm   = wdata[7:4];
          next_st.pin_level = wdata[3:0];
        end
        init_pkg::OFS_FRAME: begin
          next_st.frame = wdata[3:0];
          next_st.blink = wdata[5:4];
        end
        init_pkg::OFS_CTRL: begin
          if (wdata[init_pkg::CTRL_SWRST]) begin
            // Built on next_st so that the cleared read data are not brought back.
            next_st = defaults(next_st);
          end
        end
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        init_pkg::OFS_MODE:   next_st.rdata = {1'b0, st.bias, st.duty};
        init_pkg::OFS_POWER:  next_st.rdata = {3'h0, st.power};
        init_pkg::OFS_PINS:   next_st.rdata = {st.pin_pwm, st.pin_level};
        init_pkg::OFS_FRAME:  next_st.rdata = {2'h0, st.blink, st.frame};
        init_pkg::OFS_STATUS: next_st.rdata = {7'h00, st.busy};
        default:              next_st.rdata = 8'h00;
      endcase
    end
  end

  // Register the state; reset takes the defaults.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= defaults('0);
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata   = st.rdata;
  assign duty    = st.duty;
  assign bias    = st.bias;
  assign power   = st.power;
  assign pin_pwm = st.pin_pwm;
  assign frame   = st.frame;
  assign blink   = st.blink;
  assign busy    = st.busy;

  // Feed the output stage.
  assign cfg.duty      = st.duty;
  assign cfg.bias      = st.bias;
  assign cfg.power     = st.power;
  assign cfg.pin_pwm   = st.pin_pwm;
  assign cfg.pin_level = st.pin_level;
  assign cfg.frame     = st.frame;
  assign cfg.blink     = st.blink;
  assign cfg.busy      = st.busy;

  out_stage #(.NGPO(NGPO)) u_out (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .cfg                (cfg.dst),
    .drive_on           (drive_on),
    .general_output_pin (general_output_pin)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Drive mode, frame, blink and pin mode fields land on their defaults one edge after reset.
  reset_defaults_a: assert property (@(posedge clk)
    sys_rst |=> (duty == 4'hF) && (bias == 3'h5) && (frame == 4'hA) && (blink == 2'h0)
    && (pin_pwm == 4'h0)) else $error("bad defaults");
  drive_mode_a: assert property (@(posedge clk)
    sys_rst |=> (duty == 4'hF) && (bias == 3'h5)) else $error("drive mode not default");

  // Oscillator, display and the analog helpers all come up switched off.
  osc_off_a: assert property (@(posedge clk)
    sys_rst |=> !power[0] && !power[1] && !drive_on)
    else $error("osc or display on after reset");
  analog_off_a: assert property (@(posedge clk)
    sys_rst |=> power[4:2] == 3'h0) else $error("analog helpers on");

  // General outputs in binary mode, frame code and blinking at their defaults.
  pin_binary_a: assert property (@(posedge clk)
    sys_rst |=> pin_pwm == 4'h0) else $error("general outputs not binary");
  frame_rate_a: assert property (@(posedge clk)
    sys_rst |=> frame == 4'hA) else $error("frame code wrong");
  blink_off_a: assert property (@(posedge clk)
    sys_rst |=> blink == 2'h0) else $error("blink not off");

  // A software reset reloads the defaults and reopens the init window.
  soft_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wr && !busy && addr == init_pkg::OFS_CTRL && wdata[init_pkg::CTRL_SWRST])
    |=> busy && power == 5'h00 && frame == 4'hA && pin_pwm == 4'h0 && duty == 4'hF)
    else $error("software reset failed");

  // The init window lasts at least eight cycles and closes exactly on the last count.
  init_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busy) |-> busy [*8]) else $error("init too short");
  init_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    (busy && st.cnt == init_pkg::CNT_W'(INIT_CYCLES - 1)) |=> !busy)
    else $error("init window did not close");

  // Writes during the init window are dropped, so the defaults survive it.
  busy_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wr && busy) |=> (power == $past(power)) && (duty == $past(duty))
    && (frame == $past(frame)) && (pin_pwm == $past(pin_pwm)))
    else $error("write taken during init");

  // Read data stand for one cycle only and read as zero otherwise.
  rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !rd |=> rdata == 8'h00) else $error("read data not cleared");

  // Scenarios: init end, software reset, display on, pulse-width select, status read.
  init_done_c:   cover property (@(posedge clk) disable iff (sys_rst) $fell(busy));
  soft_rst_c:    cover property (@(posedge clk) disable iff (sys_rst)
    wr && !busy && addr == init_pkg::OFS_CTRL && wdata[init_pkg::CTRL_SWRST]);
  display_c:     cover property (@(posedge clk) disable iff (sys_rst) drive_on);
  pwm_select_c:  cover property (@(posedge clk) disable iff (sys_rst) pin_pwm != 4'h0);
  status_read_c: cover property (@(posedge clk) disable iff (sys_rst)
    rd && addr == init_pkg::OFS_STATUS);

endmodule

/* File: host_model.sv */
// Host model that drives the register port of the init block.
module host_model (
  // Clock and status.
  input  wire logic       clk,
  input  wire logic       busy,
  input  wire logic [7:0] rdata,
  // Register port.
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles with both strobes low from time zero.
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Waits until initialisation is over, for at most 1000 cycles, and counts the cycles in n.
  task automatic wait_ready(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // One write cycle; the strobe drops after the edge that takes it.
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // One read cycle; the data stand only in the cycle after the strobe.
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Software reset, for supplies whose ramp cannot be trusted.
  task automatic soft_reset();
    bus_wr(4'h4, 8'h01);
  endtask
endmodule

/* File: test_lcd_driver_power_on_init.sv */
// Self-checking testbench for the power-on initialisation block.
module test_lcd_driver_power_on_init;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       sys_rst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [3:0] duty;
  logic [2:0] bias;
  logic [4:0] power;
  logic [3:0] pin_pwm;
  logic [3:0] frame;
  logic [1:0] blink;
  logic       busy;
  logic       drive_on;
  logic [3:0] general_output_pin;
  int         miscompares = 0;
  int         tests_run = 0;
  // Shortened init window used in simulation.
  localparam int INIT_SIM = 20;

  host_model host_u (.clk(clk), .busy(busy), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));

  lcd_init #(.INIT_CYCLES(INIT_SIM), .NGPO(4)) dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .duty(duty), .bias(bias), .power(power),
    .pin_pwm(pin_pwm), .frame(frame), .blink(blink), .busy(busy), .drive_on(drive_on),
    .general_output_pin(general_output_pin));

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Default outputs, as seen after either kind of reset.
  task automatic check_defaults();
    chk({4'h0, duty}, 8'h0F);
    chk({5'h0, bias}, 8'h05);
    chk({3'h0, power}, 8'h00);
    chk({4'h0, pin_pwm}, 8'h00);
    chk({4'h0, frame}, 8'h0A);
    chk({6'h0, blink}, 8'h00);
    chk({3'h0, drive_on, general_output_pin}, 8'h00);
  endtask

  // Power-up: defaults out and in every register, busy until the window ends.
  task automatic test_por();
    logic [7:0] d;
    logic [7:0] want [4] = '{8'h5F, 8'h00, 8'h00, 8'h0A};
    int n;
    #1 chk({7'h0, busy}, 8'h01);
    check_defaults();
    host_u.wait_ready(n);
    chk({7'h0, busy}, 8'h00);
    chk(8'(n), 8'(INIT_SIM - 1));
    for (int i = 0; i < 4; i++) begin
      host_u.bus_rd(4'(i), d);
      chk(d, want[i]);
    end
    host_u.bus_rd(4'h5, d);
    chk(d, 8'h00);
  endtask

  // Settings take effect, then a software reset restores all defaults.
  task automatic test_swrst();
    logic [7:0] d;
    int n;
    host_u.bus_wr(4'h0, 8'h23);
    host_u.bus_wr(4'h1, 8'h1F);
    host_u.bus_wr(4'h2, 8'hF5);
    host_u.bus_wr(4'h3, 8'h27);
    @(posedge clk);
    #1 chk({duty, 1'b0, bias}, 8'h32);
    chk({power[3:0], pin_pwm}, 8'hFF);
    chk({drive_on, general_output_pin, frame[2:0]}, 8'hAF);
    chk({6'h0, blink}, 8'h02);
    host_u.bus_rd(4'hF, d);
    chk(d, 8'h00);
    host_u.soft_reset();
    @(posedge clk);
    #1 chk({7'h0, busy}, 8'h01);
    check_defaults();
    host_u.bus_wr(4'h1, 8'h1F);
    #1 chk({3'h0, power}, 8'h00);
    host_u.wait_ready(n);
    chk(8'(n), 8'(INIT_SIM - 3));
    host_u.bus_rd(4'h0, d);
    chk(d, 8'h5F);
    @(posedge clk);
    #1 chk(rdata, 8'h00);
  endtask

  // The clock runs at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Reset for five cycles, then the scenarios in order.
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    test_por();
    test_swrst();
    test_done();
  end

  // Cuts a hang short well beyond the expected run of under a hundred cycles.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
